// ==== shared/twbsm_pkg.sv ====
`default_nettype none
package twbsm_pkg;
    // Bus state codes as software sees them
    typedef enum logic [1:0] {
        BS_UNKNOWN = 2'b00,
        BS_IDLE = 2'b01,
        BS_OWNER = 2'b10,
        BS_BUSY = 2'b11
    } twbsm_bus_t;

    // Code software writes to force idle
    localparam logic [1:0] BS_IDLE_CODE = 2'h1;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0000,
        M_START = 4'b0001,
        M_LOW = 4'b0010,
        M_WAITH = 4'b0011,
        M_HIGH = 4'b0100,
        M_HOLD = 4'b0101,
        M_RS_LOW = 4'b0110,
        M_RS_WAIT = 4'b0111,
        M_P_LOW = 4'b1000,
        M_P_WAIT = 4'b1001
    } twbsm_mst_t;

    // Timing in ns, derived counts at the core clock rate
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned T_LOW_NS = 4700;
    localparam int unsigned T_HIGH_NS = 4000;
    localparam int unsigned T_HDDAT_NS = 300;
    localparam int unsigned T_TIMEOUT_NS = 50000;
    localparam logic [15:0] LOW_CNT = 16'((T_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] HIGH_CNT = 16'((T_HIGH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [15:0] HDDAT_CNT = 16'((T_HDDAT_NS * CLK_MHZ + 999) / 1000);
    localparam int unsigned TIMEOUT_CYC_DEF = (T_TIMEOUT_NS * CLK_MHZ) / 1000;

    // Bit positions within a nine-bit packet, and the counter zero value
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : twbsm_pkg
`default_nettype wire

// ==== logic/twbsm_line_sync.sv ====
`default_nettype none
module twbsm_line_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_s_o,
    output logic sda_s_o,
    output logic scl_rise_o,
    output logic start_o,
    output logic stop_o,
    output logic line_edge_o
);
    logic [1:0] scl_meta_ff;
    logic [1:0] sda_meta_ff;
    logic scl_prev_ff;
    logic sda_prev_ff;

    // Two flops per pin, then one more stage for edges
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_meta_ff <= 2'h3;
            sda_meta_ff <= 2'h3;
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= {scl_meta_ff[0], scl_i};
            sda_meta_ff <= {sda_meta_ff[0], sda_i};
            scl_prev_ff <= scl_meta_ff[1];
            sda_prev_ff <= sda_meta_ff[1];
        end
    end

    assign scl_s_o = scl_meta_ff[1];
    assign sda_s_o = sda_meta_ff[1];
    assign scl_rise_o = scl_meta_ff[1] && !scl_prev_ff;
    assign start_o = scl_meta_ff[1] && scl_prev_ff && sda_prev_ff && !sda_meta_ff[1];
    assign stop_o = scl_meta_ff[1] && scl_prev_ff && !sda_prev_ff && sda_meta_ff[1];
    assign line_edge_o = (scl_meta_ff[1] != scl_prev_ff) || (sda_meta_ff[1] != sda_prev_ff);
endmodule : twbsm_line_sync
`default_nettype wire

// ==== logic/twbsm_monitor.sv ====
`default_nettype none
module twbsm_monitor #(
    parameter int unsigned TIMEOUT_CYC = twbsm_pkg::TIMEOUT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_en_i,
    input wire logic timeout_en_i,
    input wire logic bs_wr_i,
    input wire logic [1:0] bs_wdata_i,
    input wire logic cmd_start_i,
    input wire logic [7:0] addr_i,
    input wire logic cmd_byte_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_nack_i,
    input wire logic cmd_stop_i,
    input wire logic slv_addressed_i,
    input wire logic slv_hold_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output twbsm_pkg::twbsm_bus_t line_condition_field_o,
    output logic done_o,
    output logic rx_ack_o,
    output logic [7:0] rx_data_o,
    output logic arb_lost_o,
    output logic hold_o,
    output logic refused_o
);
    import twbsm_pkg::*;

    logic scl_s, sda_s, scl_rise, start_det, stop_det, line_edge;
    twbsm_bus_t bus_state_ff;
    twbsm_mst_t m_state_ff;
    logic [15:0] cnt_ff;
    logic [3:0] bit_ff;
    logic [3:0] mon_bit_ff;
    logic [7:0] sh_ff;
    logic [7:0] rx_data_ff;
    logic [31:0] idle_cnt_ff;
    logic dir_rd_ff, tx_ff, nack_ff, ack_ff, rd_open_ff;
    logic scl_drv_ff, sda_drv_ff, slv_stretch_ff;
    logic done_ff, rx_ack_ff, lost_ff, arb_lost_ff, refused_ff, timeout_pls;
    logic end_high, force_idle;

    twbsm_line_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s_o(scl_s),
        .sda_s_o(sda_s),
        .scl_rise_o(scl_rise),
        .start_o(start_det),
        .stop_o(stop_det),
        .line_edge_o(line_edge)
    );

    assign end_high = (cnt_ff == HIGH_CNT) || (!scl_s && cnt_ff != CNT_ZERO);
    assign force_idle = bs_wr_i && bs_wdata_i == BS_IDLE_CODE;

    // Master byte engine
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state_ff <= M_IDLE;
            cnt_ff <= CNT_ZERO;
            bit_ff <= BIT_FIRST;
            sh_ff <= 8'h00;
            rx_data_ff <= 8'h00;
            dir_rd_ff <= 1'b0;
            tx_ff <= 1'b0;
            nack_ff <= 1'b0;
            ack_ff <= 1'b0;
            rd_open_ff <= 1'b0;
            scl_drv_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
            done_ff <= 1'b0;
            rx_ack_ff <= 1'b0;
            lost_ff <= 1'b0;
            arb_lost_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else if (!master_en_i) begin
            m_state_ff <= M_IDLE;
            cnt_ff <= CNT_ZERO;
            scl_drv_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
            done_ff <= 1'b0;
            lost_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            lost_ff <= 1'b0;
            refused_ff <= 1'b0;
            unique case (m_state_ff)
                M_IDLE: begin
                    if (cmd_start_i && bus_state_ff == BS_IDLE) begin
                        m_state_ff <= M_START;
                        sda_drv_ff <= 1'b1;
                        cnt_ff <= CNT_ZERO;
                        sh_ff <= addr_i;
                        dir_rd_ff <= addr_i[0];
                        tx_ff <= 1'b1;
                        bit_ff <= BIT_FIRST;
                        arb_lost_ff <= 1'b0;
                        rd_open_ff <= 1'b0;
                    end else if (cmd_start_i) begin
                        refused_ff <= 1'b1;
                    end
                end
                M_START: begin
                    if (cnt_ff == HIGH_CNT) begin
                        scl_drv_ff <= 1'b1;
                        cnt_ff <= CNT_ZERO;
                        m_state_ff <= M_LOW;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                M_LOW: begin
                    if (cnt_ff == HDDAT_CNT) begin
                        if (bit_ff == BIT_ACK) begin
                            sda_drv_ff <= !tx_ff && !nack_ff;
                        end else begin
                            sda_drv_ff <= tx_ff && !sh_ff[7];
                        end
                    end
                    if (cnt_ff == LOW_CNT) begin
                        scl_drv_ff <= 1'b0;
                        cnt_ff <= CNT_ZERO;
                        m_state_ff <= M_WAITH;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                M_WAITH: begin
                    if (scl_s) begin
                        m_state_ff <= M_HIGH;
                        cnt_ff <= CNT_ZERO;
                    end
                end
                M_HIGH: begin
                    if (cnt_ff == CNT_ZERO) begin
                        if (bit_ff == BIT_ACK) begin
                            ack_ff <= sda_s;
                        end else begin
                            sh_ff <= {sh_ff[6:0], sda_s};
                        end
                    end
                    if (cnt_ff == CNT_ZERO && bit_ff != BIT_ACK && tx_ff && !sda_drv_ff
                            && !sda_s) begin
                        m_state_ff <= M_IDLE;
                        lost_ff <= 1'b1;
                        arb_lost_ff <= 1'b1;
                    end else if (end_high) begin
                        scl_drv_ff <= 1'b1;
                        cnt_ff <= CNT_ZERO;
                        if (bit_ff == BIT_ACK) begin
                            done_ff <= 1'b1;
                            rx_ack_ff <= ack_ff;
                            rx_data_ff <= sh_ff;
                            sda_drv_ff <= 1'b0;
                            rd_open_ff <= !tx_ff && !nack_ff;
                            if (tx_ff && ack_ff) begin
                                m_state_ff <= M_P_LOW;
                            end else begin
                                m_state_ff <= M_HOLD;
                            end
                        end else begin
                            bit_ff <= bit_ff + 4'h1;
                            m_state_ff <= M_LOW;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                M_HOLD: begin
                    cnt_ff <= CNT_ZERO;
                    if (cmd_start_i) begin
                        m_state_ff <= M_RS_LOW;
                        sh_ff <= addr_i;
                        dir_rd_ff <= addr_i[0];
                        tx_ff <= 1'b1;
                        bit_ff <= BIT_FIRST;
                        rd_open_ff <= 1'b0;
                    end else if (cmd_byte_i) begin
                        m_state_ff <= M_LOW;
                        tx_ff <= !dir_rd_ff;
                        sh_ff <= tx_data_i;
                        nack_ff <= rx_nack_i;
                        bit_ff <= BIT_FIRST;
                    end else if (cmd_stop_i && rd_open_ff) begin
                        refused_ff <= 1'b1;
                    end else if (cmd_stop_i) begin
                        m_state_ff <= M_P_LOW;
                    end
                end
                M_RS_LOW, M_P_LOW: begin
                    if (cnt_ff == HDDAT_CNT) begin
                        sda_drv_ff <= m_state_ff == M_P_LOW;
                    end
                    if (cnt_ff == LOW_CNT) begin
                        scl_drv_ff <= 1'b0;
                        cnt_ff <= CNT_ZERO;
                        m_state_ff <= m_state_ff == M_P_LOW ? M_P_WAIT : M_RS_WAIT;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
                M_RS_WAIT, M_P_WAIT: begin
                    if (m_state_ff == M_RS_WAIT && scl_s && !sda_s
                            && cnt_ff != CNT_ZERO) begin
                        m_state_ff <= M_IDLE;
                        lost_ff <= 1'b1;
                        arb_lost_ff <= 1'b1;
                    end else if (!scl_s) begin
                        cnt_ff <= CNT_ZERO;
                    end else if (cnt_ff == HIGH_CNT) begin
                        cnt_ff <= CNT_ZERO;
                        sda_drv_ff <= m_state_ff == M_RS_WAIT;
                        m_state_ff <= m_state_ff == M_RS_WAIT ? M_START : M_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Slave stretch only after SCL seen low, around its acknowledge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slv_stretch_ff <= 1'b0;
        end else if (!slv_hold_i || !slv_addressed_i) begin
            slv_stretch_ff <= 1'b0;
        end else if (!scl_s && (mon_bit_ff == BIT_ACK || mon_bit_ff == BIT_FIRST)) begin
            slv_stretch_ff <= 1'b1;
        end
    end

    // Bus bit counter, nine bits per packet
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mon_bit_ff <= BIT_FIRST;
        end else if (start_det) begin
            mon_bit_ff <= BIT_FIRST;
        end else if (scl_rise) begin
            mon_bit_ff <= mon_bit_ff == BIT_ACK ? BIT_FIRST : mon_bit_ff + 4'h1;
        end
    end

    // Inactive bus timeout
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt_ff <= 32'h00000000;
        end else if (line_edge || !timeout_en_i || !master_en_i) begin
            idle_cnt_ff <= 32'h00000000;
        end else if (idle_cnt_ff != TIMEOUT_CYC) begin
            idle_cnt_ff <= idle_cnt_ff + 32'h00000001;
        end
    end
    assign timeout_pls = timeout_en_i && idle_cnt_ff == TIMEOUT_CYC - 1;

    // Bus state monitor
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_state_ff <= BS_UNKNOWN;
        end else if (!master_en_i) begin
            bus_state_ff <= BS_UNKNOWN;
        end else if (force_idle) begin
            bus_state_ff <= BS_IDLE;
        end else begin
            unique case (bus_state_ff)
                BS_UNKNOWN: begin
                    if (stop_det || timeout_pls) begin
                        bus_state_ff <= BS_IDLE;
                    end
                end
                BS_IDLE: begin
                    if (start_det) begin
                        bus_state_ff <= m_state_ff == M_START ? BS_OWNER : BS_BUSY;
                    end
                end
                BS_OWNER: begin
                    if (lost_ff) begin
                        bus_state_ff <= BS_BUSY;
                    end else if (stop_det) begin
                        bus_state_ff <= BS_IDLE;
                    end
                end
                BS_BUSY: begin
                    if (stop_det || timeout_pls) begin
                        bus_state_ff <= BS_IDLE;
                    end
                end
            endcase
        end
    end

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_drv_ff || slv_stretch_ff;
    assign sda_oe_o = sda_drv_ff;
    assign line_condition_field_o = bus_state_ff;
    assign done_o = done_ff;
    assign rx_ack_o = rx_ack_ff;
    assign rx_data_o = rx_data_ff;
    assign arb_lost_o = arb_lost_ff;
    assign hold_o = m_state_ff == M_HOLD;
    assign refused_o = refused_ff;

    sequence s_rd_open_stop;
        master_en_i && m_state_ff == M_HOLD && rd_open_ff && cmd_stop_i && !cmd_start_i
            && !cmd_byte_i;
    endsequence
    sequence s_byte_end;
        master_en_i && m_state_ff == M_HIGH && bit_ff == BIT_ACK && end_high;
    endsequence

    disabled_unknown_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !master_en_i |=> bus_state_ff == BS_UNKNOWN)
        else $error("bus state not unknown while disabled");
    force_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_en_i && force_idle |=> bus_state_ff == BS_IDLE)
        else $error("idle write did not force idle");
    stop_to_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_en_i && !force_idle && stop_det && bus_state_ff inside {BS_UNKNOWN, BS_BUSY}
        |=> bus_state_ff == BS_IDLE)
        else $error("stop did not give idle");
    foreign_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_en_i && !force_idle && bus_state_ff == BS_IDLE && start_det
        && m_state_ff != M_START |=> bus_state_ff == BS_BUSY)
        else $error("foreign start did not give busy");
    own_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_en_i && !force_idle && bus_state_ff == BS_IDLE && start_det
        && m_state_ff == M_START |=> bus_state_ff == BS_OWNER)
        else $error("own start did not give owner");
    idle_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        m_state_ff == M_IDLE ##1 m_state_ff == M_START |-> $past(bus_state_ff) == BS_IDLE)
        else $error("start issued on non-idle bus");
    arb_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lost_ff |-> m_state_ff == M_IDLE && !scl_drv_ff ##1 m_state_ff == M_IDLE)
        else $error("lines kept after lost arbitration");
    wait_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        master_en_i && m_state_ff == M_WAITH && !scl_s |=> m_state_ff == M_WAITH)
        else $error("bit timing advanced while SCL held");
    stretch_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(slv_stretch_ff) |-> $past(!scl_s) && $past(slv_addressed_i))
        else $error("stretch began with SCL high");
    read_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rd_open_stop |=> m_state_ff == M_HOLD && refused_ff)
        else $error("stop after acked read byte");
    nine_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_byte_end |=> done_ff ##1 !done_ff)
        else $error("byte end without one done pulse");
endmodule : twbsm_monitor
`default_nettype wire

// ==== sim/twbsm_slave_model.sv ====
`default_nettype none
module twbsm_slave_model #(
    parameter logic [6:0] SLV_ADDR = 7'h2a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic nack_data_i,
    input wire logic [7:0] rd_byte_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic [7:0] wr_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int bit_n = 0;
    logic [7:0] shift_q = 8'h00;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic in_addr = 1'b0;
    logic m_ack = 1'b1;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        wr_byte_o = 8'h00;
    end
    // Start or Stop seen on the wire
    always @(sda_i) begin
        if (scl_i === 1'b1) begin
            bit_n = 0;
            in_addr = !sda_i;
            sel = 1'b0;
        end
    end
    always @(posedge scl_i) begin
        if (bit_n < 8) begin
            shift_q = {shift_q[6:0], sda_i};
        end else begin
            m_ack = sda_i;
        end
        bit_n = bit_n + 1;
    end
    // Slave never arbitrates, only acks, sends or holds SCL low for 200 ns when selected
    always @(negedge scl_i) begin
        #20;
        if (bit_n == 8) begin
            if (in_addr) begin
                sel = (shift_q[7:1] == SLV_ADDR);
                rd = shift_q[0];
            end else if (sel && !rd) begin
                wr_byte_o = shift_q;
            end
            sda_oe_o = sel && (in_addr || (!rd && !nack_data_i));
            scl_oe_o = sel;
            #200;
            scl_oe_o = 1'b0;
        end else if (bit_n == 9) begin
            in_addr = 1'b0;
            bit_n = 0;
            sda_oe_o = sel && rd && !m_ack && !rd_byte_i[7];
        end else begin
            sda_oe_o = sel && rd && !in_addr && !m_ack && !rd_byte_i[7 - bit_n];
        end
    end
endmodule : twbsm_slave_model
`default_nettype wire

// ==== sim/twbsm_monitor_bench.sv ====
`default_nettype none
module twbsm_monitor_bench;
    import twbsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] SLV_ADDR = 7'h2a;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic master_en_i = 1'b1, timeout_en_i = 1'b0, bs_wr_i = 1'b0, cmd_start_i = 1'b0;
    logic cmd_byte_i = 1'b0, rx_nack_i = 1'b0, cmd_stop_i = 1'b0, slv_nack = 1'b0;
    logic fm_scl_oe = 1'b0, fm_sda_oe = 1'b0;
    logic [1:0] bs_wdata_i = 2'h0;
    logic [7:0] addr_i = 8'h00, tx_data_i = 8'h00;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, done_o, rx_ack_o, arb_lost_o, hold_o, refused_o;
    logic s_scl_oe, s_sda_oe;
    logic [7:0] rx_data_o, wr_byte;
    twbsm_bus_t line_condition_field_o;
    int miscompares = 0, total_checks = 0, refusals = 0;
    wire logic scl_w = !(scl_oe_o | s_scl_oe | fm_scl_oe);
    wire logic sda_w = !(sda_oe_o | s_sda_oe | fm_sda_oe);
    always @(posedge clk_i) if (refused_o === 1'b1) refusals++;
    twbsm_monitor #(.TIMEOUT_CYC(200)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .master_en_i(master_en_i),
        .timeout_en_i(timeout_en_i), .bs_wr_i(bs_wr_i), .bs_wdata_i(bs_wdata_i),
        .cmd_start_i(cmd_start_i), .addr_i(addr_i), .cmd_byte_i(cmd_byte_i),
        .tx_data_i(tx_data_i), .rx_nack_i(rx_nack_i), .cmd_stop_i(cmd_stop_i),
        .slv_addressed_i(1'b0), .slv_hold_i(1'b0), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .line_condition_field_o(line_condition_field_o), .done_o(done_o),
        .rx_ack_o(rx_ack_o), .rx_data_o(rx_data_o), .arb_lost_o(arb_lost_o),
        .hold_o(hold_o), .refused_o(refused_o)
    );
    twbsm_slave_model #(.SLV_ADDR(SLV_ADDR)) slave (
        .scl_i(scl_w), .sda_i(sda_w), .nack_data_i(slv_nack), .rd_byte_i(8'h3c),
        .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .wr_byte_o(wr_byte)
    );
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic final_report;
        $display("TB: checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic link(input logic scl_oe, input logic sda_oe);
        fm_scl_oe = scl_oe;
        fm_sda_oe = sda_oe;
        tick(20);
    endtask : link
    task automatic fstart;
        link(1'b0, 1'b1);
        repeat (3) begin
            link(1'b1, 1'b1);
            link(1'b0, 1'b1);
        end
    endtask : fstart
    task automatic fstop;
        link(1'b1, 1'b1);
        link(1'b0, 1'b1);
        link(1'b0, 1'b0);
    endtask : fstop
    task automatic pulse(input logic [2:0] sel, input logic [7:0] val);
        {cmd_start_i, cmd_byte_i, cmd_stop_i} = sel;
        addr_i = val;
        tx_data_i = val;
        tick(1);
        {cmd_start_i, cmd_byte_i, cmd_stop_i} = 3'b000;
    endtask : pulse
    task automatic st_is(input twbsm_bus_t st);
        chk({6'h00, line_condition_field_o}, {6'h00, st});
    endtask : st_is
    task automatic wait_state(input twbsm_bus_t st);
        int n;
        n = 0;
        while (line_condition_field_o !== st && n < 30000) begin
            tick(1);
            n++;
        end
        st_is(st);
    endtask : wait_state
    task automatic wait_hold;
        int n;
        n = 0;
        tick(2);
        while (hold_o !== 1'b1 && n < 30000) begin
            tick(1);
            n++;
        end
        chk({7'h00, hold_o}, 8'h01);
    endtask : wait_hold
    task automatic bs_write(input logic [1:0] val);
        bs_wdata_i = val;
        bs_wr_i = 1'b1;
        tick(1);
        bs_wr_i = 1'b0;
        tick(4);
    endtask : bs_write
    initial begin
        tick(6);
        rst_i = 1'b0;
        tick(2);
        st_is(BS_UNKNOWN);
        pulse(3'b100, {SLV_ADDR, 1'b0});
        tick(4);
        chk(8'(refusals), 8'h01);
        fstart;
        fstop;
        wait_state(BS_IDLE);
        $display("TB: test first_stop done");
        fstart;
        tick(300);
        st_is(BS_BUSY);
        timeout_en_i = 1'b1;
        tick(250);
        st_is(BS_IDLE);
        timeout_en_i = 1'b0;
        fstop;
        master_en_i = 1'b0;
        tick(4);
        st_is(BS_UNKNOWN);
        master_en_i = 1'b1;
        bs_write(2'h2);
        st_is(BS_UNKNOWN);
        bs_write(BS_IDLE_CODE);
        st_is(BS_IDLE);
        $display("TB: test state_moves done");
        slv_nack = 1'b1;
        pulse(3'b100, {SLV_ADDR, 1'b0});
        wait_state(BS_OWNER);
        wait_hold;
        chk({7'h00, rx_ack_o}, 8'h00);
        pulse(3'b010, 8'ha5);
        wait_state(BS_IDLE);
        chk(wr_byte, 8'ha5);
        chk({7'h00, rx_ack_o}, 8'h01);
        $display("TB: test write done");
        pulse(3'b100, {SLV_ADDR, 1'b1});
        wait_hold;
        chk({7'h00, rx_ack_o}, 8'h00);
        rx_nack_i = 1'b1;
        pulse(3'b010, 8'h00);
        wait_hold;
        chk(rx_data_o, 8'h3c);
        chk({7'h00, rx_ack_o}, 8'h01);
        pulse(3'b001, 8'h00);
        wait_state(BS_IDLE);
        chk({6'h00, scl_o, sda_o}, 8'h00);
        chk({7'h00, arb_lost_o}, 8'h00);
        $display("TB: test read done");
        final_report;
    end
    initial begin
        tick(120000);
        miscompares++;
        final_report;
    end
endmodule : twbsm_monitor_bench
`default_nettype wire
